// [hdl/tcirq_top.sv]
// timer/counters, interrupt flags and wake enables of the core
// assumes one clock; the instruction clock equals i_ref_clk
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "tcirq_map.svh"

// What this block does
// - software clears timer flags, never sets
// - flag reads return flags AND mask
// - conversion and comparator flags set by hardware
// - wake only for enabled sources
// - pulse timer underflows set bits 7,6
// - aux overflows set bits 5,4,3
// - external pin edge sets flag bit 2
// - port change bit 1, main overflow bit 0
// - control bit 7 picks interrupt edge
// - global enable read-only, set/cleared by instructions
// - bit 5 picks internal or pin clock
// - bit 4 picks counted pin edge
// - prescaler 1:1 or 1:2 up to 1:256
// - main counter overflows every 256 counts
// - comparator result bit read-only
// - two-bit field selects comparator function
// - aux a run, source, edge bits
// - aux b eight or sixteen bits wide
// - aux b run, source, edge bits
// - aux c run, source, edge bits
module tcirq_top (
   // clock and reset
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_reset_n,
   // register port
   input  wire tcirq_pkg::tcirq_bus_req_t i_bus,
   output logic [7:0]                   o_rdata,
   // pins
   input  wire logic                    i_ext_irq_pin,
   input  wire logic                    i_main_pin,
   input  wire logic                    i_aux_a_pin,
   input  wire logic                    i_aux_b_pin,
   input  wire logic                    i_aux_c_pin,
   input  wire logic [7:0]              i_port5,
   // analog and pulse timer events
   input  wire logic                    i_conv_done,
   input  wire logic                    i_cmp_out,
   input  wire logic                    i_low_pulse_uf,
   input  wire logic                    i_high_pulse_uf,
   // core instruction events
   input  wire logic                    i_irq_on_instr,
   input  wire logic                    i_irq_off_instr,
   input  wire logic                    i_irq_return_instr,
   input  wire logic                    i_irq_taken,
   // status and control out
   output logic                         o_wake,
   output logic                         o_irq_global_on,
   output logic [1:0]                   o_cmp_mode,
   output logic                         o_cmp_pin_drive,
   output logic                         o_main_pin_is_io
);
   import tcirq_pkg::*;

   tcirq_state_t q;
   tcirq_state_t d;

   logic [4:0]  rise;
   logic [4:0]  fall;
   logic        ext_evt;
   logic        main_in;
   logic [7:0]  pre_mask;
   logic        main_inc;
   logic        main_ovf;
   logic        a_inc;
   logic        a_ovf;
   logic        b_inc;
   logic        b_ovf;
   logic        c_inc;
   logic        c_ovf;
   logic        cmp_chg;
   logic        p5_chg;
   logic [7:0]  rf_set;
   logic [1:0]  re_set;
   logic [7:0]  re_raw;
   logic [7:0]  rd_val;
   logic        wr_re;
   logic        wr_rf;
   logic        wr_main_counter_config_only;

   default clocking cb_ref @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_reset_n);

   // internal source ticks every cycle, pin source on chosen edge
   function automatic logic pin_tick(input logic src, input logic edge_sel,
                                     input logic r, input logic f);
      pin_tick = src ? (edge_sel ? f : r) : 1'b1;
   endfunction

   // edges seen on second and third stages
   assign rise = q.s2 & ~q.s3;
   assign fall = ~q.s2 & q.s3;

   // selected pin edge sets the flag
   assign ext_evt = q.main_counter_config[`TCIRQ_CT_EDGE] ? fall[`TCIRQ_PIN_EXT] : rise[`TCIRQ_PIN_EXT];

   assign main_in = pin_tick(q.main_counter_config[`TCIRQ_CT_SRC], q.main_counter_config[`TCIRQ_CT_CEDGE],
                             rise[`TCIRQ_PIN_MAIN], fall[`TCIRQ_PIN_MAIN]);

   // prescale ratio two to the code plus one
   assign pre_mask = 8'hff >> (3'h7 - q.main_counter_config[2:0]);
   assign main_inc = main_in && (!q.main_counter_config[`TCIRQ_CT_PSON] || ((q.pre & pre_mask) == pre_mask));

   assign main_ovf = main_inc && (q.tcc == 8'hff);

   assign a_inc = q.comparator_aux_a_config[2] && pin_tick(q.comparator_aux_a_config[1], q.comparator_aux_a_config[0],
                                         rise[`TCIRQ_PIN_A], fall[`TCIRQ_PIN_A]);
   assign a_ovf = a_inc && (q.ca == 8'hff);

   assign b_inc = q.aux_b_c_counter_config[6] && pin_tick(q.aux_b_c_counter_config[5], q.aux_b_c_counter_config[4],
                                         rise[`TCIRQ_PIN_B], fall[`TCIRQ_PIN_B]);
   // aux b wrap in either width
   assign b_ovf = b_inc && (q.aux_b_c_counter_config[`TCIRQ_C9_BWIDE] ? (q.cb == 16'hffff)
                                                   : (q.cb[7:0] == 8'hff));

   assign c_inc = q.aux_b_c_counter_config[2] && pin_tick(q.aux_b_c_counter_config[1], q.aux_b_c_counter_config[0],
                                         rise[`TCIRQ_PIN_C], fall[`TCIRQ_PIN_C]);
   assign c_ovf = c_inc && (q.cc == 8'hff);

   assign cmp_chg = i_cmp_out != q.cmp_prev;
   assign p5_chg  = i_port5 != q.p5_prev;

   assign rf_set = {i_low_pulse_uf, i_high_pulse_uf, c_ovf, b_ovf, a_ovf,
                    ext_evt, p5_chg, main_ovf};
   assign re_set = {i_conv_done, cmp_chg};

   assign re_raw = {2'b00, q.re[5:1], 1'b0};
   assign wr_re  = i_bus.wr && (i_bus.addr == `TCIRQ_OFF_RE);
   assign wr_rf  = i_bus.wr && (i_bus.addr == `TCIRQ_OFF_RF);
   // config write with no instruction event beside it
   assign wr_main_counter_config_only = i_bus.wr && (i_bus.addr == `TCIRQ_OFF_MAIN_COUNTER_CONFIG) && !i_irq_on_instr
                         && !i_irq_return_instr && !i_irq_off_instr && !i_irq_taken;

   // read mux, unmapped words read zero
   always_comb begin
      rd_val = 8'h00;
      case (i_bus.addr)
         `TCIRQ_OFF_RE:      rd_val = re_raw & q.mske;
         `TCIRQ_OFF_RF:      rd_val = q.rf & q.mskf;
         `TCIRQ_OFF_MAIN_COUNTER_CONFIG:    rd_val = q.main_counter_config;
         `TCIRQ_OFF_COMPARATOR_AUX_A_CONFIG:   rd_val = {2'b00, i_cmp_out, q.comparator_aux_a_config[4:0]};
         `TCIRQ_OFF_AUX_B_C_COUNTER_CONFIG:   rd_val = q.aux_b_c_counter_config;
         `TCIRQ_OFF_MSKE:    rd_val = q.mske;
         `TCIRQ_OFF_MSKF:    rd_val = q.mskf;
         `TCIRQ_OFF_MAIN:    rd_val = q.tcc;
         `TCIRQ_OFF_AUXA:    rd_val = q.ca;
         `TCIRQ_OFF_AUXB_LO: rd_val = q.cb[7:0];
         `TCIRQ_OFF_AUXB_HI: rd_val = q.cb[15:8];
         `TCIRQ_OFF_AUXC:    rd_val = q.cc;
         default:            rd_val = 8'h00;
      endcase
   end

   always_comb begin
      d = q;
      d.s1       = {i_aux_c_pin, i_aux_b_pin, i_aux_a_pin, i_main_pin, i_ext_irq_pin};
      d.s2       = q.s1;
      d.s3       = q.s2;
      d.p5_prev  = i_port5;
      d.cmp_prev = i_cmp_out;

      // prescaler counts source ticks; counters follow
      if (main_in) begin
         d.pre = q.pre + 8'h01;
      end
      if (main_inc) begin
         d.tcc = q.tcc + 8'h01;
      end
      if (a_inc) begin
         d.ca = q.ca + 8'h01;
      end
      // narrow mode holds the high byte
      if (b_inc) begin
         if (q.aux_b_c_counter_config[`TCIRQ_C9_BWIDE]) begin
            d.cb = q.cb + 16'h0001;
         end else begin
            d.cb = {q.cb[15:8], q.cb[7:0] + 8'h01};
         end
      end
      if (c_inc) begin
         d.cc = q.cc + 8'h01;
      end

      // writes only clear; a same-cycle event wins
      d.rf = (wr_rf ? (q.rf & i_bus.wdata) : q.rf) | rf_set;

      // flags in 5:4 clear-only, set wins
      d.re[5:4] = (wr_re ? (q.re[5:4] & i_bus.wdata[5:4]) : q.re[5:4]) | re_set;
      if (wr_re) begin
         d.re[3:1] = i_bus.wdata[3:1];
      end

      // global enable is not writable by software
      if (i_bus.wr && (i_bus.addr == `TCIRQ_OFF_MAIN_COUNTER_CONFIG)) begin
         d.main_counter_config = {i_bus.wdata[7], q.main_counter_config[`TCIRQ_CT_GIE], i_bus.wdata[5:0]};
         d.pre  = 8'h00;
      end
      if (i_irq_off_instr || i_irq_taken) begin
         d.main_counter_config[`TCIRQ_CT_GIE] = 1'b0;
      end else if (i_irq_on_instr || i_irq_return_instr) begin
         d.main_counter_config[`TCIRQ_CT_GIE] = 1'b1;
      end

      if (i_bus.wr && (i_bus.addr == `TCIRQ_OFF_COMPARATOR_AUX_A_CONFIG)) begin
         d.comparator_aux_a_config = {3'b000, i_bus.wdata[4:0]};
      end
      if (i_bus.wr && (i_bus.addr == `TCIRQ_OFF_AUX_B_C_COUNTER_CONFIG)) begin
         d.aux_b_c_counter_config = {i_bus.wdata[7:4], 1'b0, i_bus.wdata[2:0]};
      end
      if (i_bus.wr && (i_bus.addr == `TCIRQ_OFF_MSKE)) begin
         d.mske = i_bus.wdata;
      end
      if (i_bus.wr && (i_bus.addr == `TCIRQ_OFF_MSKF)) begin
         d.mskf = i_bus.wdata;
      end
      // counter loads override a same-cycle count
      if (i_bus.wr && (i_bus.addr == `TCIRQ_OFF_MAIN)) begin
         d.tcc = i_bus.wdata;
      end
      if (i_bus.wr && (i_bus.addr == `TCIRQ_OFF_AUXA)) begin
         d.ca = i_bus.wdata;
      end
      if (i_bus.wr && (i_bus.addr == `TCIRQ_OFF_AUXB_LO)) begin
         d.cb[7:0] = i_bus.wdata;
      end
      if (i_bus.wr && (i_bus.addr == `TCIRQ_OFF_AUXB_HI)) begin
         d.cb[15:8] = i_bus.wdata;
      end
      if (i_bus.wr && (i_bus.addr == `TCIRQ_OFF_AUXC)) begin
         d.cc = i_bus.wdata;
      end

      // read data stand one cycle only
      d.rdata = i_bus.rd ? rd_val : 8'h00;

      // pending flag gated by its wake enable
      d.wake = (q.re[`TCIRQ_RE_CONV] & q.re[`TCIRQ_RE_CONV_WK])
             | (q.re[`TCIRQ_RE_CMP] & q.re[`TCIRQ_RE_CMP_WK])
             | (q.rf[1] & q.re[`TCIRQ_RE_PC_WK]);
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         q      <= '0;
         q.main_counter_config <= `TCIRQ_MAIN_COUNTER_CONFIG_RST;
      end else begin
         q <= d;
      end
   end

   assign o_rdata          = q.rdata;
   assign o_wake           = q.wake;
   assign o_irq_global_on  = q.main_counter_config[`TCIRQ_CT_GIE];
   // comparator function field to the analog side
   assign o_cmp_mode       = q.comparator_aux_a_config[4:3];
   assign o_cmp_pin_drive  = q.comparator_aux_a_config[4];
   // shared pin is plain I/O on internal clock
   assign o_main_pin_is_io = ~q.main_counter_config[`TCIRQ_CT_SRC];

   a_rf_clear_only: assert property (
      (wr_rf && !i_bus.wdata[0] && !main_ovf) |=> !q.rf[0])
      else $error("timer flag not cleared by write");

   a_rf_no_set: assert property (
      (wr_rf && rf_set == 8'h00) |=> q.rf == ($past(q.rf) & $past(i_bus.wdata)))
      else $error("timer flag set by write");

   a_re_read_masked: assert property (
      (i_bus.rd && i_bus.addr == `TCIRQ_OFF_RE) |=> o_rdata == ($past(re_raw) & $past(q.mske)))
      else $error("status read not masked");

   a_rf_read_masked: assert property (
      (i_bus.rd && i_bus.addr == `TCIRQ_OFF_RF) |=> o_rdata == ($past(q.rf) & $past(q.mskf)))
      else $error("timer flag read not masked");

   a_rdata_idle_zero: assert property (
      !i_bus.rd |=> o_rdata == 8'h00)
      else $error("read data outside read cycle");

   a_conv_flag_set: assert property (
      (i_conv_done || cmp_chg) |=> (q.re[5] || q.re[4]) ##1 (q.re[5] || q.re[4] || $past(wr_re)))
      else $error("analog event flag missing");

   a_wake_gated: assert property (
      o_wake |-> ($past(q.re[3]) || $past(q.re[2]) || $past(q.re[1])))
      else $error("wake without enable");

   a_wake_port: assert property (
      (q.rf[1] && q.re[1]) |=> o_wake)
      else $error("port change wake missing");

   a_pulse_flags: assert property (
      (i_low_pulse_uf && i_high_pulse_uf) |=> q.rf[7] && q.rf[6])
      else $error("pulse timer flag missing");

   a_aux_a_wrap: assert property (
      (a_ovf && !i_bus.wr) |=> q.rf[3] && q.ca == 8'h00)
      else $error("aux a overflow wrong");

   a_aux_c_wrap: assert property (
      (c_ovf && !i_bus.wr) |=> q.rf[5] && q.cc == 8'h00)
      else $error("aux c overflow wrong");

   a_ext_flag_kept: assert property (
      (q.rf[2] && !wr_rf) |=> q.rf[2])
      else $error("external flag lost");

   a_ext_edge_flag: assert property (
      (q.main_counter_config[7] && !i_bus.wr && $fell(q.s2[0])) |=> q.rf[2])
      else $error("external edge flag missing");

   a_ext_rise_flag: assert property (
      (!q.main_counter_config[7] && $rose(q.s2[0])) |=> q.rf[2])
      else $error("external rising flag missing");

   a_port_chg_flag: assert property (
      p5_chg |=> q.rf[1])
      else $error("port change flag missing");

   a_gie_cleared: assert property (
      i_irq_taken |=> !o_irq_global_on)
      else $error("global enable not cleared");

   a_gie_set: assert property (
      ((i_irq_on_instr || i_irq_return_instr) && !i_irq_off_instr && !i_irq_taken)
      |=> o_irq_global_on)
      else $error("global enable not set");

   a_gie_no_write: assert property (
      (wr_main_counter_config_only) |=> o_irq_global_on == $past(o_irq_global_on))
      else $error("global enable written by software");

   a_main_one_one: assert property (
      (!q.main_counter_config[5] && !q.main_counter_config[3] && !i_bus.wr) |=> q.tcc == $past(q.tcc) + 8'h01)
      else $error("main counter not 1:1");

   a_main_wrap: assert property (
      (main_ovf && !i_bus.wr) |=> q.tcc == 8'h00 && q.rf[0])
      else $error("main counter wrap wrong");

   a_cmp_read_live: assert property (
      (i_bus.rd && i_bus.addr == `TCIRQ_OFF_COMPARATOR_AUX_A_CONFIG) |=> o_rdata[5] == $past(i_cmp_out))
      else $error("comparator bit wrong");

   a_cmp_mode_load: assert property (
      (i_bus.wr && i_bus.addr == `TCIRQ_OFF_COMPARATOR_AUX_A_CONFIG) |=> o_cmp_mode == $past(i_bus.wdata[4:3]))
      else $error("comparator mode not loaded");

   a_aux_a_stopped: assert property (
      (!q.comparator_aux_a_config[2] && !i_bus.wr) |=> q.ca == $past(q.ca))
      else $error("aux a counts while off");

   a_aux_b_narrow: assert property (
      (!q.aux_b_c_counter_config[7] && b_inc && !i_bus.wr) |=> q.cb[15:8] == $past(q.cb[15:8]))
      else $error("aux b high byte moved");

   a_aux_b_wide: assert property (
      (q.aux_b_c_counter_config[7] && b_inc && q.cb == 16'hffff && !i_bus.wr) |=> q.cb == 16'h0000 && q.rf[4])
      else $error("aux b wide wrap wrong");

   a_single_edge: assert property (
      rise[`TCIRQ_PIN_MAIN] |=> !rise[`TCIRQ_PIN_MAIN])
      else $error("one pin edge gave two events");

endmodule

// [hdl/tcirq_map.svh]
// register offsets, field positions and reset values of the timer block
// assumes a 4-bit word address on the register port
`ifndef TCIRQ_MAP_SVH
`define TCIRQ_MAP_SVH

// register offsets
`define TCIRQ_OFF_RE      4'h0
`define TCIRQ_OFF_RF      4'h1
`define TCIRQ_OFF_MAIN_COUNTER_CONFIG    4'h2
`define TCIRQ_OFF_COMPARATOR_AUX_A_CONFIG   4'h3
`define TCIRQ_OFF_AUX_B_C_COUNTER_CONFIG   4'h4
`define TCIRQ_OFF_MSKE    4'h5
`define TCIRQ_OFF_MSKF    4'h6
`define TCIRQ_OFF_MAIN    4'h7
`define TCIRQ_OFF_AUXA    4'h8
`define TCIRQ_OFF_AUXB_LO 4'h9
`define TCIRQ_OFF_AUXB_HI 4'ha
`define TCIRQ_OFF_AUXC    4'hb

// conversion_comparator_irq_wake fields
`define TCIRQ_RE_CONV     5
`define TCIRQ_RE_CMP      4
`define TCIRQ_RE_CONV_WK  3
`define TCIRQ_RE_CMP_WK   2
`define TCIRQ_RE_PC_WK    1

// main_counter_config fields
`define TCIRQ_CT_EDGE     7
`define TCIRQ_CT_GIE      6
`define TCIRQ_CT_SRC      5
`define TCIRQ_CT_CEDGE    4
`define TCIRQ_CT_PSON     3

// comparator_aux_a_config and aux_b_c_counter_config fields
`define TCIRQ_C8_CMPR     5
`define TCIRQ_C9_BWIDE    7

// pin synchroniser lanes
`define TCIRQ_PIN_EXT     0
`define TCIRQ_PIN_MAIN    1
`define TCIRQ_PIN_A       2
`define TCIRQ_PIN_B       3
`define TCIRQ_PIN_C       4

// reset values
`define TCIRQ_MAIN_COUNTER_CONFIG_RST    8'h80
`define TCIRQ_REG_RST     8'h00

`endif

// [hdl/tcirq_pkg.sv]
// types of the timer and interrupt flag block
// assumes nothing of its surroundings
package tcirq_pkg;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tcirq_bus_req_t;

   typedef struct packed {
      logic [4:0]  s1;
      logic [4:0]  s2;
      logic [4:0]  s3;
      logic [7:0]  p5_prev;
      logic        cmp_prev;
      logic [7:0]  re;
      logic [7:0]  rf;
      logic [7:0]  main_counter_config;
      logic [7:0]  comparator_aux_a_config;
      logic [7:0]  aux_b_c_counter_config;
      logic [7:0]  mske;
      logic [7:0]  mskf;
      logic [7:0]  pre;
      logic [7:0]  tcc;
      logic [7:0]  ca;
      logic [15:0] cb;
      logic [7:0]  cc;
      logic [7:0]  rdata;
      logic        wake;
   } tcirq_state_t;

endpackage

// [tb/tcirq_pin_model.sv]
// pin model for the count and external interrupt pins
// assumes the block samples its pins on i_ref_clk
`timescale 1ns/1ps
module tcirq_pin_model (
   // clock
   input  wire logic i_ref_clk,
   // pins
   output logic [4:0] o_pins
);
   initial begin
      o_pins = 5'h00;
   end
   // levels held well past the synchroniser depth so no edge is lost
   task automatic toggle(input int lane, input int n);
      for (int k = 0; k < n; k++) begin
         @(posedge i_ref_clk);
         o_pins[lane] <= ~o_pins[lane];
         repeat (6) @(posedge i_ref_clk);
      end
   endtask
endmodule

// [tb/testbench.sv]
// self-checking bench of the timer and interrupt flag block
// assumes the register port and pin model; drives on the rising edge
`timescale 1ns/1ps
`include "tcirq_map.svh"
module testbench;
   import tcirq_pkg::*;
   logic           clk;
   logic           rst_n;
   tcirq_bus_req_t b;
   logic [7:0]     rdata;
   logic [4:0]     pins;
   logic [7:0]     port5;
   logic           cmp;
   logic [6:0]     ev;
   logic           wake;
   logic           gie;
   logic [1:0]     cmode;
   logic           cdrv;
   logic           pio;
   logic [7:0]     d;
   logic [7:0]     e;
   int             mismatches;
   int             comparisons;
   logic [3:0]     cfg_off [4] = '{`TCIRQ_OFF_MAIN_COUNTER_CONFIG, `TCIRQ_OFF_COMPARATOR_AUX_A_CONFIG,
                                   `TCIRQ_OFF_AUX_B_C_COUNTER_CONFIG, `TCIRQ_OFF_AUX_B_C_COUNTER_CONFIG};
   logic [3:0]     cnt_off [4] = '{`TCIRQ_OFF_MAIN, `TCIRQ_OFF_AUXA,
                                   `TCIRQ_OFF_AUXB_LO, `TCIRQ_OFF_AUXC};
   logic [7:0]     rise [4] = '{8'ha0, 8'h06, 8'h60, 8'h06};
   logic [7:0]     edg [4] = '{8'h10, 8'h01, 8'h10, 8'h01};

   tcirq_top dut (
      .i_ref_clk(clk), .i_reset_n(rst_n), .i_bus(b), .o_rdata(rdata),
      .i_ext_irq_pin(pins[0]), .i_main_pin(pins[1]), .i_aux_a_pin(pins[2]),
      .i_aux_b_pin(pins[3]), .i_aux_c_pin(pins[4]), .i_port5(port5),
      .i_conv_done(ev[0]), .i_cmp_out(cmp), .i_low_pulse_uf(ev[1]),
      .i_high_pulse_uf(ev[2]), .i_irq_on_instr(ev[3]), .i_irq_off_instr(ev[4]),
      .i_irq_return_instr(ev[5]), .i_irq_taken(ev[6]), .o_wake(wake),
      .o_irq_global_on(gie), .o_cmp_mode(cmode), .o_cmp_pin_drive(cdrv),
      .o_main_pin_is_io(pio)
   );
   tcirq_pin_model pm (.i_ref_clk(clk), .o_pins(pins));

   always #50 clk = ~clk;

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      b.addr <= a;
      b.wdata <= v;
      b.wr <= 1'b1;
      @(posedge clk);
      b.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      b.addr <= a;
      b.rd <= 1'b1;
      @(posedge clk);
      b.rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
      rd(a, d);
      chk(d, exp);
   endtask
   task automatic pulse(input int k);
      @(posedge clk);
      ev[k] <= 1'b1;
      @(posedge clk);
      ev[k] <= 1'b0;
   endtask
   // ends off the edge so registered outputs have settled
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wrap_up();
      if (mismatches == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #2000000;
      mismatches++;
      wrap_up();
   end

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      b = '0;
      ev = '0;
      port5 = 8'h00;
      cmp = 1'b0;
      mismatches = 0;
      comparisons = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rchk(`TCIRQ_OFF_MAIN_COUNTER_CONFIG, 8'h80);
      chk({7'h00, pio}, 8'h01);
      rchk(4'hf, 8'h00);
      // bit 0 masked: the main counter free-runs out of reset
      wr(`TCIRQ_OFF_MSKF, 8'hfe);
      wr(`TCIRQ_OFF_MSKE, 8'hff);
      @(posedge clk);
      port5 <= 8'h01;
      pulse(1);
      pulse(2);
      pulse(0);
      @(posedge clk);
      cmp <= 1'b1;
      idle(2);
      rchk(`TCIRQ_OFF_RF, 8'hc2);
      wr(`TCIRQ_OFF_MSKF, 8'h02);
      rchk(`TCIRQ_OFF_RF, 8'h02);
      wr(`TCIRQ_OFF_MSKF, 8'hfe);
      wr(`TCIRQ_OFF_RF, 8'hbf);
      rchk(`TCIRQ_OFF_RF, 8'h82);
      wr(`TCIRQ_OFF_RF, 8'h00);
      wr(`TCIRQ_OFF_RF, 8'hff);
      rchk(`TCIRQ_OFF_RF, 8'h00);
      rchk(`TCIRQ_OFF_RE, 8'h30);
      chk({7'h00, wake}, 8'h00);
      wr(`TCIRQ_OFF_RE, 8'h38);
      idle(2);
      chk({7'h00, wake}, 8'h01);
      wr(`TCIRQ_OFF_RE, 8'h08);
      idle(2);
      chk({7'h00, wake}, 8'h00);
      rchk(`TCIRQ_OFF_RE, 8'h08);
      // comparator and port change wake sources in turn
      wr(`TCIRQ_OFF_RE, 8'h04);
      @(posedge clk);
      cmp <= 1'b0;
      idle(3);
      chk({7'h00, wake}, 8'h01);
      wr(`TCIRQ_OFF_RE, 8'h02);
      idle(2);
      chk({7'h00, wake}, 8'h00);
      @(posedge clk);
      port5 <= 8'h03;
      idle(3);
      chk({7'h00, wake}, 8'h01);
      wr(`TCIRQ_OFF_RF, 8'h00);
      wr(`TCIRQ_OFF_RE, 8'h00);
      @(posedge clk);
      cmp <= 1'b1;
      idle(2);
      chk({7'h00, wake}, 8'h00);
      pulse(3);
      idle(1);
      chk({7'h00, gie}, 8'h01);
      wr(`TCIRQ_OFF_MAIN_COUNTER_CONFIG, 8'h80);
      rchk(`TCIRQ_OFF_MAIN_COUNTER_CONFIG, 8'hc0);
      pulse(6);
      idle(1);
      chk({7'h00, gie}, 8'h00);
      pulse(5);
      idle(1);
      chk({7'h00, gie}, 8'h01);
      pulse(4);
      idle(1);
      chk({7'h00, gie}, 8'h00);
      for (int m = 0; m < 4; m++) begin
         wr(`TCIRQ_OFF_COMPARATOR_AUX_A_CONFIG, 8'(m << 3));
         idle(2);
         chk({6'h00, cmode}, 8'(m));
         chk({7'h00, cdrv}, {7'h00, m[1]});
         rchk(`TCIRQ_OFF_COMPARATOR_AUX_A_CONFIG, 8'(m << 3) | 8'h20);
      end
      wr(`TCIRQ_OFF_COMPARATOR_AUX_A_CONFIG, 8'h00);
      // each pass: five toggles give three counted and two ignored edges
      for (int i = 0; i < 4; i++) begin
         wr(cfg_off[i], rise[i]);
         wr(cnt_off[i], 8'h00);
         pm.toggle(i + 1, 5);
         idle(4);
         rchk(cnt_off[i], 8'h03);
         if (i == 0)
            chk({7'h00, pio}, 8'h00);
         wr(cfg_off[i], rise[i] | edg[i]);
         wr(cnt_off[i], 8'h00);
         pm.toggle(i + 1, 5);
         idle(4);
         rchk(cnt_off[i], 8'h03);
         wr(cfg_off[i], (i == 0) ? 8'h80 : 8'h00);
      end
      wr(`TCIRQ_OFF_RF, 8'h00);
      pm.toggle(0, 1);
      idle(2);
      rchk(`TCIRQ_OFF_RF, 8'h00);
      pm.toggle(0, 1);
      idle(2);
      rchk(`TCIRQ_OFF_RF, 8'h04);
      wr(`TCIRQ_OFF_MAIN_COUNTER_CONFIG, 8'h00);
      wr(`TCIRQ_OFF_RF, 8'h00);
      pm.toggle(0, 1);
      idle(2);
      rchk(`TCIRQ_OFF_RF, 8'h04);
      wr(`TCIRQ_OFF_RF, 8'h00);
      pm.toggle(0, 1);
      idle(2);
      rchk(`TCIRQ_OFF_RF, 8'h00);
      wr(`TCIRQ_OFF_MAIN_COUNTER_CONFIG, 8'h80);
      wr(`TCIRQ_OFF_MAIN, 8'h00);
      wr(`TCIRQ_OFF_RF, 8'h00);
      wr(`TCIRQ_OFF_MSKF, 8'h01);
      wr(`TCIRQ_OFF_MAIN, 8'hf0);
      idle(8);
      rchk(`TCIRQ_OFF_RF, 8'h00);
      idle(8);
      rchk(`TCIRQ_OFF_RF, 8'h01);
      // config write restarts the prescaler; at ratios up to 1:2 the
      // count load two cycles later swallows one tick, so seven remain
      for (int c = -1; c < 8; c++) begin
         wr(`TCIRQ_OFF_MAIN_COUNTER_CONFIG, (c < 0) ? 8'h80 : 8'h88 | 8'(c));
         wr(`TCIRQ_OFF_MAIN, 8'h00);
         idle(((c < 0) ? 8 : 8 << (c + 1)) - 2);
         rd(`TCIRQ_OFF_MAIN, d);
         e = (c < 1) ? 8'h07 : 8'h08;
         chk(d, e);
      end
      wr(`TCIRQ_OFF_MAIN_COUNTER_CONFIG, 8'h80);
      wr(`TCIRQ_OFF_COMPARATOR_AUX_A_CONFIG, 8'h04);
      wr(`TCIRQ_OFF_AUX_B_C_COUNTER_CONFIG, 8'h44);
      wr(`TCIRQ_OFF_RF, 8'h00);
      wr(`TCIRQ_OFF_MSKF, 8'h38);
      wr(`TCIRQ_OFF_AUXA, 8'hf8);
      wr(`TCIRQ_OFF_AUXB_LO, 8'hf8);
      wr(`TCIRQ_OFF_AUXC, 8'hf8);
      idle(20);
      rchk(`TCIRQ_OFF_RF, 8'h38);
      rchk(`TCIRQ_OFF_AUXB_HI, 8'h00);
      wr(`TCIRQ_OFF_COMPARATOR_AUX_A_CONFIG, 8'h00);
      wr(`TCIRQ_OFF_AUX_B_C_COUNTER_CONFIG, 8'hc0);
      wr(`TCIRQ_OFF_RF, 8'h00);
      wr(`TCIRQ_OFF_AUXB_HI, 8'h00);
      wr(`TCIRQ_OFF_AUXB_LO, 8'hf8);
      idle(20);
      rchk(`TCIRQ_OFF_AUXB_HI, 8'h01);
      rchk(`TCIRQ_OFF_RF, 8'h00);
      wrap_up();
   end
endmodule
